/* watchdog_and_bus_mode_control_regs_tb_top.sv */
// Self-checking bench for the watchdog and bus mode control registers.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_bus_mode_control_regs_tb_top
   import wbmc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk, chip_select_n, sdi, sdo, sdo_oe, fo, aux_v, aux_ls, wd_sd, wd_window_select, wd_bw, o_int, spi_fail;
   logic [2:0] wd_per;
   logic [10:0] wd_ms;
   wbmc_bus_cfg_t cfg;
   wbmc_mode_t mode = WBMC_M_INIT;
   logic [4:0] ev = 5'h00;
   logic sys_err = 1'b0, latch = 1'b0, wake = 1'b0, status = 1'b0;
   logic [7:0] rd_v;
   int n_errors = 0, total_checks = 0, n_int = 0, n_fail = 0;
   logic [7:0] can_tab [8] = '{8'h61, 8'he5, 8'h6b, 8'h41, 8'h52, 8'h21, 8'h10, 8'hc5};
   logic [10:0] ms_tab [7] = '{11'h00a, 11'h014, 11'h032, 11'h064, 11'h0c8, 11'h1f4, 11'h3e8};

   // Clock at 125 MHz
   always #4 clk = ~clk;

   // Counts interrupt and serial fault pulses
   always @(posedge clk) begin
      if (o_int === 1'b1) n_int <= n_int + 1;
      if (spi_fail === 1'b1) n_fail <= n_fail + 1;
   end

   // ----------------------------------------
   // Instances
   // ----------------------------------------
   wbmc_host_model host_u (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_csn(chip_select_n), .o_sdi(sdi));
   wbmc_regs dut_u (
      .I_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CHIP_SELECT_N(chip_select_n), .I_SDI(sdi),
      .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_MODE(mode), .I_SOFT_RESET(ev[0]),
      .I_RESTART_ENTRY(ev[1]), .I_SLEEP_ENTRY(ev[2]), .I_STOP_ENTRY(ev[3]),
      .I_FAILSAFE_ENTRY(ev[4]), .I_SYSTEM_ERROR_FLAG(sys_err), .I_FAILURE_LATCH(latch),
      .I_WAKE_EVT(wake), .I_STATUS_EVT(status), .O_FAILURE_OUTPUTS(fo),
      .O_AUX_VOLTAGE_SELECT(aux_v), .O_AUX_LOAD_SHARE(aux_ls), .O_WD_STOP_DISABLE(wd_sd),
      .O_WD_WINDOW_SELECT(wd_window_select), .O_WD_START_ON_BUS_WAKE(wd_bw),
      .O_WD_PERIOD_SELECT(wd_per), .O_WD_PERIOD_MS(wd_ms), .O_BUS_CFG(cfg), .O_INT(o_int),
      .O_SPI_FAIL(spi_fail)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb = 16);
      host_u.xfer({1'b1, a, d}, nb, rd_v);
   endtask : wr

   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      host_u.xfer({1'b0, a, 8'h00}, 16, rd_v);
      chk(rd_v, exp);
   endtask : rchk

   // One-cycle pulse on a sequencer entry line
   task automatic pulse(input int k);
      @(posedge clk) ev[k] <= 1'b1;
      @(posedge clk) ev <= 5'h00;
      repeat (3) @(posedge clk);
   endtask : pulse

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Watchdog against a hung run
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      give_verdict();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      // Reset values and unmapped address
      rchk(7'h03, 8'h14);
      rchk(7'h04, 8'h20);
      rchk(7'h05, 8'h00);
      rchk(7'h10, 8'h00);
      chk(sdo_oe, 1'b0);
      chk(wd_ms, 11'h0c8);
      // Watchdog fields and reserved bit
      wr(7'h03, 8'hff);
      rchk(7'h03, 8'hf7);
      chk({wd_sd, wd_window_select, wd_bw, wd_per}, 6'h3f);
      chk(wd_ms, 11'h000);
      for (int c = 0; c < 7; c++) begin
         wr(7'h03, {^c[2:0], 4'h0, c[2:0]});
         chk(wd_ms, ms_tab[c]);
         chk({wd_sd, wd_window_select, wd_bw}, 3'h0);
      end
      wr(7'h03, 8'h01);
      rchk(7'h03, 8'h06);
      chk(n_fail, 1);
      // Bus control fields
      wr(7'h04, 8'hff);
      chk(cfg[10:3], 8'hff);
      wr(7'h04, 8'h00);
      chk(cfg[10:3], 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(7'h04, {3'h0, m[1:0], 3'h0});
         chk(cfg.lin_first_mode, m[1:0]);
      end
      // Incomplete frame leaves the register alone
      wr(7'h04, 8'h5a, 15);
      rchk(7'h04, 8'h18);
      // CAN mode on sleep and stop entry
      for (int i = 0; i < 8; i++) begin
         wr(7'h04, {5'h00, can_tab[i][7:5]});
         @(posedge clk) sys_err <= can_tab[i][3];
         pulse(can_tab[i][4] ? 3 : 2);
         chk(cfg.can_mode, can_tab[i][2:0]);
         sys_err <= 1'b0;
      end
      // Second bus register, peak threshold lock in stop
      wr(7'h05, 8'hff);
      rchk(7'h05, 8'h23);
      chk({cfg.peak_current_threshold, cfg.lin_second_mode}, 3'h7);
      @(posedge clk) mode <= WBMC_M_STOP;
      wr(7'h05, 8'h02);
      chk({cfg.peak_current_threshold, cfg.lin_second_mode}, 3'h6);
      chk(n_fail, 1);
      @(posedge clk) mode <= WBMC_M_NORMAL;
      wr(7'h05, 8'h01);
      chk({cfg.peak_current_threshold, cfg.lin_second_mode}, 3'h1);
      // Fail-safe load
      wr(7'h04, 8'hff);
      wr(7'h05, 8'h22);
      wr(7'h07, 8'h80);
      pulse(4);
      rchk(7'h04, 8'he9);
      rchk(7'h05, 8'h01);
      rchk(7'h07, 8'h87);
      // Interrupt sources under the global setting
      @(posedge clk) status <= 1'b1;
      @(posedge clk) status <= 1'b0;
      repeat (3) @(posedge clk);
      chk(n_int, 1);
      wr(7'h07, 8'h07);
      @(posedge clk) status <= 1'b1;
      @(posedge clk) status <= 1'b0;
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      repeat (3) @(posedge clk);
      chk(n_int, 2);
      // Failure outputs
      wr(7'h02, 8'h20);
      chk(fo, 1'b1);
      pulse(1);
      chk(fo, 1'b0);
      rchk(7'h02, 8'h00);
      @(posedge clk) latch <= 1'b1;
      wr(7'h02, 8'h20);
      wr(7'h02, 8'h00);
      chk(fo, 1'b1);
      @(posedge clk) latch <= 1'b0;
      repeat (2) @(posedge clk);
      chk(fo, 1'b0);
      // Soft reset against power-on reset
      wr(7'h02, 8'hff);
      rchk(7'h02, 8'hfb);
      wr(7'h04, 8'hff);
      pulse(0);
      rchk(7'h02, 8'h88);
      chk({aux_v, aux_ls}, 2'h3);
      rchk(7'h03, 8'h14);
      rchk(7'h04, 8'h20);
      @(posedge clk) rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rchk(7'h02, 8'h00);
      give_verdict();
   end
endmodule : watchdog_and_bus_mode_control_regs_tb_top
`default_nettype wire

/* wbmc_consts.svh */
// Offsets, field positions, reset values and watchdog periods of the
// watchdog and bus mode control registers.
// Assumes inclusion by bare name from the package and the register module.
`ifndef WBMC_CONSTS_SVH
`define WBMC_CONSTS_SVH
// Register addresses (7-bit frame address)
`define WBMC_ADDR_HW 7'h02
`define WBMC_ADDR_WD 7'h03
`define WBMC_ADDR_BUS1 7'h04
`define WBMC_ADDR_BUS2 7'h05
`define WBMC_ADDR_WK2 7'h07
// Reset values
`define WBMC_RST_HW 8'h00
`define WBMC_RST_WD 8'h14
`define WBMC_RST_BUS1 8'h20
`define WBMC_RST_BUS2 8'h00
`define WBMC_RST_WK2 8'h07
// Writable-bit masks, reserved bits clear
`define WBMC_MASK_HW 8'hfb
`define WBMC_MASK_WD 8'hf7
`define WBMC_MASK_BUS1 8'hff
`define WBMC_MASK_BUS2 8'h23
`define WBMC_MASK_WK2 8'ha7
// Bits kept by a soft reset in the mode and supply register
`define WBMC_HW_SOFT_KEEP 8'h88
// Field positions
`define WBMC_HW_FO 5
`define WBMC_BUS2_PEAK 5
`define WBMC_WK2_INTG 7
// Fail-safe load values and the bits they keep
`define WBMC_FS_BUS1 8'h09
`define WBMC_FS_BUS1_KEEP 8'he0
`define WBMC_FS_BUS2 8'h01
`define WBMC_FS_WK2 8'h07
`define WBMC_FS_WK2_KEEP 8'ha0
// Watchdog periods in ms
`define WBMC_WD_MS0 11'd10
`define WBMC_WD_MS1 11'd20
`define WBMC_WD_MS2 11'd50
`define WBMC_WD_MS3 11'd100
`define WBMC_WD_MS4 11'd200
`define WBMC_WD_MS5 11'd500
`define WBMC_WD_MS6 11'd1000
`endif

/* wbmc_host_model.sv */
// Host microcontroller model: drives serial frames into the control registers.
// Assumes frames of 16 bits, MSB first, serial clock idle low at 160 ns period.
`timescale 1ns/10ps
`default_nettype none
module wbmc_host_model (
   // Clock
   input wire logic i_clk,
   // Serial pins
   input wire logic i_sdo,
   output logic o_sclk,
   output logic o_csn,
   output logic o_sdi
);
   // ----------------------------------------
   // Idle levels
   // ----------------------------------------
   initial begin
      o_sclk = 1'b0;
      o_csn = 1'b1;
      o_sdi = 1'b0;
   end

   // ----------------------------------------
   // Frame transfer
   // ----------------------------------------
   // Shifts nb bits out and returns the last eight bits seen on the data line
   task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge i_clk) o_csn <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (int i = nb - 1; i >= 0; i--) begin
         @(posedge i_clk) o_sdi <= f[i];
         repeat (9) @(posedge i_clk);
         rd = {rd[6:0], i_sdo};
         o_sclk <= 1'b1;
         repeat (10) @(posedge i_clk);
         o_sclk <= 1'b0;
      end
      // Data byte was taken before rises 9 to 16; no sample after the last fall
      repeat (10) @(posedge i_clk);
      o_csn <= 1'b1;
      // Released data line no longer shows the last bit
      o_sdi <= ~o_sdi;
      repeat (12) @(posedge i_clk);
   endtask : xfer
endmodule : wbmc_host_model
`default_nettype wire

/* wbmc_pkg.sv */
// Types shared by the watchdog and bus mode control registers.
// Assumes the constants header sits in the same folder.
`include "wbmc_consts.svh"
package wbmc_pkg;
   // Chip mode reported by the internal sequencer
   typedef enum logic [2:0] {
      WBMC_M_INIT = 3'b000,
      WBMC_M_NORMAL = 3'b001,
      WBMC_M_STOP = 3'b010,
      WBMC_M_SLEEP = 3'b011,
      WBMC_M_RESTART = 3'b100,
      WBMC_M_FAILSAFE = 3'b101
   } wbmc_mode_t;
   // Transceiver configuration handed to the analog front ends
   typedef struct packed {
      logic lin_fast;
      logic lin_low_slope;
      logic lin_tx_timeout_enable;
      logic [1:0] lin_first_mode;
      logic [2:0] can_mode;
      logic peak_current_threshold;
      logic [1:0] lin_second_mode;
   } wbmc_bus_cfg_t;
endpackage : wbmc_pkg

/* wbmc_regs.sv */
// Watchdog and bus mode control registers, written over a 16-bit serial
// frame: bit 15 write flag, bits 14:8 address, bits 7:0 data, MSB first.
// Assumes the sequencer drives mode and entry pulses on I_CLK.
`timescale 1ns/10ps
`default_nettype none
`include "wbmc_consts.svh"
module wbmc_regs
   import wbmc_pkg::*;
#(
   parameter int unsigned FRAME_BITS = 16
) (
   // Clock and power-on reset
   input wire logic I_CLK,
   input wire logic I_RST,
   // Serial pins
   input wire logic I_SCLK,
   input wire logic I_CHIP_SELECT_N,
   input wire logic I_SDI,
   output logic O_SDO,
   output logic O_SDO_OE,
   // Sequencer
   input wire wbmc_mode_t I_MODE,
   input wire logic I_SOFT_RESET,
   input wire logic I_RESTART_ENTRY,
   input wire logic I_SLEEP_ENTRY,
   input wire logic I_STOP_ENTRY,
   input wire logic I_FAILSAFE_ENTRY,
   input wire logic I_SYSTEM_ERROR_FLAG,
   input wire logic I_FAILURE_LATCH,
   input wire logic I_WAKE_EVT,
   input wire logic I_STATUS_EVT,
   // Supply and failure outputs
   output logic O_FAILURE_OUTPUTS,
   output logic O_AUX_VOLTAGE_SELECT,
   output logic O_AUX_LOAD_SHARE,
   // Watchdog configuration
   output logic O_WD_STOP_DISABLE,
   output logic O_WD_WINDOW_SELECT,
   output logic O_WD_START_ON_BUS_WAKE,
   output logic [2:0] O_WD_PERIOD_SELECT,
   output logic [10:0] O_WD_PERIOD_MS,
   // Transceivers, interrupt and fault
   output wbmc_bus_cfg_t O_BUS_CFG,
   output logic O_INT,
   output logic O_SPI_FAIL
);
   if (FRAME_BITS != 16) begin : g_chk
      $error("FRAME_BITS must be 16");
   end

   //----------------------------------------------------------------
   // Pin synchronisers and edge detection
   //----------------------------------------------------------------
   logic [2:0] sclk_q, csn_q;
   logic [1:0] sdi_q;
   logic sclk_rise, sclk_fall, csn_rise, csn_fall;
   // Two flops per pin, a third stage only for edges
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sclk_q <= 3'h0;
         csn_q <= 3'h7;
         sdi_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], I_SCLK};
         csn_q <= {csn_q[1:0], I_CHIP_SELECT_N};
         sdi_q <= {sdi_q[0], I_SDI};
      end
   end
   assign sclk_rise = sclk_q[1] & ~sclk_q[2] & ~csn_q[1];
   assign sclk_fall = ~sclk_q[1] & sclk_q[2] & ~csn_q[1];
   assign csn_rise = csn_q[1] & ~csn_q[2];
   assign csn_fall = ~csn_q[1] & csn_q[2];

   //----------------------------------------------------------------
   // Frame shifter
   //----------------------------------------------------------------
   logic [15:0] rx_q;
   logic [4:0] cnt_q;
   logic [7:0] tx_q, rd_data;
   logic sdo_q;
   logic [7:0] hw_q, wd_q, bus1_q, bus2_q, wk2_q;
   // Receive bits on rising clock, count saturating at 31
   always_ff @(posedge I_CLK) begin
      if (I_RST || csn_fall) begin
         rx_q <= 16'h0000;
         cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         rx_q <= {rx_q[14:0], sdi_q[1]};
         cnt_q <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
      end
   end
   // Read data of the address in rx_q[6:0] once it is complete
   always_comb begin
      case (rx_q[6:0])
         `WBMC_ADDR_HW: rd_data = hw_q;
         `WBMC_ADDR_WD: rd_data = wd_q;
         `WBMC_ADDR_BUS1: rd_data = bus1_q;
         `WBMC_ADDR_BUS2: rd_data = bus2_q;
         `WBMC_ADDR_WK2: rd_data = wk2_q;
         default: rd_data = 8'h00;
      endcase
   end
   // Previous register value goes out on falling clock in the data byte
   always_ff @(posedge I_CLK) begin
      if (I_RST || csn_fall) begin
         tx_q <= 8'h00;
         sdo_q <= 1'b0;
      end else if (sclk_rise && cnt_q == 5'd7) begin
         tx_q <= 8'h00;
      end else if (sclk_fall && cnt_q == 5'd8) begin
         sdo_q <= rd_data[7];
         tx_q <= {rd_data[6:0], 1'b0};
      end else if (sclk_fall && cnt_q > 5'd8) begin
         sdo_q <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end
   assign O_SDO = sdo_q;
   assign O_SDO_OE = ~csn_q[1];

   //----------------------------------------------------------------
   // Write decode
   //----------------------------------------------------------------
   logic wr_ok;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic wd_par_bad;
   assign wr_ok = csn_rise && cnt_q == 5'd16 && rx_q[15];
   assign wr_addr = rx_q[14:8];
   assign wr_data = rx_q[7:0];
   assign wd_par_bad = ^wr_data;

   //----------------------------------------------------------------
   // Mode and supply register
   //----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         hw_q <= `WBMC_RST_HW;
      end else if (I_SOFT_RESET) begin
         hw_q <= hw_q & `WBMC_HW_SOFT_KEEP;
      end else if (I_RESTART_ENTRY) begin
         hw_q[`WBMC_HW_FO] <= 1'b0;
      end else if (wr_ok && wr_addr == `WBMC_ADDR_HW) begin
         hw_q <= wr_data & `WBMC_MASK_HW;
      end
   end
   // Software enable cannot release outputs held by the failure latch
   assign O_FAILURE_OUTPUTS = hw_q[`WBMC_HW_FO] | I_FAILURE_LATCH;
   assign O_AUX_VOLTAGE_SELECT = hw_q[7];
   assign O_AUX_LOAD_SHARE = hw_q[3];

   //----------------------------------------------------------------
   // Watchdog register
   //----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_RST || I_SOFT_RESET) begin
         wd_q <= `WBMC_RST_WD;
      end else if (wr_ok && wr_addr == `WBMC_ADDR_WD && !wd_par_bad) begin
         wd_q <= wr_data & `WBMC_MASK_WD;
      end
   end
   assign O_WD_STOP_DISABLE = wd_q[6];
   assign O_WD_WINDOW_SELECT = wd_q[5];
   assign O_WD_START_ON_BUS_WAKE = wd_q[4];
   assign O_WD_PERIOD_SELECT = wd_q[2:0];
   // Period lookup, reserved code gives zero
   always_comb begin
      case (wd_q[2:0])
         3'h0: O_WD_PERIOD_MS = `WBMC_WD_MS0;
         3'h1: O_WD_PERIOD_MS = `WBMC_WD_MS1;
         3'h2: O_WD_PERIOD_MS = `WBMC_WD_MS2;
         3'h3: O_WD_PERIOD_MS = `WBMC_WD_MS3;
         3'h4: O_WD_PERIOD_MS = `WBMC_WD_MS4;
         3'h5: O_WD_PERIOD_MS = `WBMC_WD_MS5;
         3'h6: O_WD_PERIOD_MS = `WBMC_WD_MS6;
         default: O_WD_PERIOD_MS = 11'h000;
      endcase
   end

   //----------------------------------------------------------------
   // First bus control register
   //----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_RST || I_SOFT_RESET) begin
         bus1_q <= `WBMC_RST_BUS1;
      end else if (I_FAILSAFE_ENTRY) begin
         bus1_q <= (bus1_q & `WBMC_FS_BUS1_KEEP) | `WBMC_FS_BUS1;
      end else if (I_SLEEP_ENTRY) begin
         // Only the low two bits move; bit 2 is never touched
         if (bus1_q[1:0] == 2'b11 && !I_SYSTEM_ERROR_FLAG) begin
            bus1_q[1:0] <= 2'b01;
         end else if (bus1_q[1:0] == 2'b10) begin
            bus1_q[1:0] <= 2'b01;
         end
      end else if (wr_ok && wr_addr == `WBMC_ADDR_BUS1) begin
         bus1_q <= wr_data;
      end
   end

   //----------------------------------------------------------------
   // Second bus control and external wake registers
   //----------------------------------------------------------------
   logic stop_mode;
   assign stop_mode = (I_MODE == WBMC_M_STOP);
   always_ff @(posedge I_CLK) begin
      if (I_RST || I_SOFT_RESET) begin
         bus2_q <= `WBMC_RST_BUS2;
      end else if (I_FAILSAFE_ENTRY) begin
         bus2_q <= `WBMC_FS_BUS2;
      end else if (wr_ok && wr_addr == `WBMC_ADDR_BUS2) begin
         bus2_q <= wr_data & `WBMC_MASK_BUS2;
         if (stop_mode) begin
            bus2_q[`WBMC_BUS2_PEAK] <= bus2_q[`WBMC_BUS2_PEAK];
         end
      end
   end
   always_ff @(posedge I_CLK) begin
      if (I_RST || I_SOFT_RESET) begin
         wk2_q <= `WBMC_RST_WK2;
      end else if (I_FAILSAFE_ENTRY) begin
         wk2_q <= (wk2_q & `WBMC_FS_WK2_KEEP) | `WBMC_FS_WK2;
      end else if (wr_ok && wr_addr == `WBMC_ADDR_WK2) begin
         wk2_q <= wr_data & `WBMC_MASK_WK2;
      end
   end
   // Transceiver configuration fields
   assign O_BUS_CFG = '{
      lin_fast: bus1_q[7],
      lin_low_slope: bus1_q[6],
      lin_tx_timeout_enable: bus1_q[5],
      lin_first_mode: bus1_q[4:3],
      can_mode: bus1_q[2:0],
      peak_current_threshold: bus2_q[`WBMC_BUS2_PEAK],
      lin_second_mode: bus2_q[1:0]
   };

   //----------------------------------------------------------------
   // Interrupt and serial access fault
   //----------------------------------------------------------------
   logic int_q, fail_q;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         int_q <= 1'b0;
      end else begin
         int_q <= I_WAKE_EVT | (wk2_q[`WBMC_WK2_INTG] & I_STATUS_EVT);
      end
   end
   // Odd watchdog parity flags a fault; a stopped peak write does not
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         fail_q <= 1'b0;
      end else begin
         fail_q <= wr_ok && wr_addr == `WBMC_ADDR_WD && wd_par_bad;
      end
   end
   assign O_INT = int_q;
   assign O_SPI_FAIL = fail_q;

   //----------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   a_fo_latch_hold: assert property (I_FAILURE_LATCH |-> O_FAILURE_OUTPUTS)
      else $error("failure outputs released while latch set");
   a_fo_restart_clr: assert property (I_RESTART_ENTRY && !I_SOFT_RESET
      |=> !hw_q[`WBMC_HW_FO])
      else $error("software failure enable not cleared by restart");
   a_soft_keep_aux: assert property (I_SOFT_RESET |=> hw_q == ($past(hw_q) & 8'h88))
      else $error("soft reset changed kept aux bits");
   a_wd_parity_gate: assert property (wr_ok && wr_addr == `WBMC_ADDR_WD && wd_par_bad
      && !I_SOFT_RESET |=> $stable(wd_q) && O_SPI_FAIL)
      else $error("odd parity watchdog write not refused");
   a_swk_hold: assert property (!wr_ok && !I_SOFT_RESET && !I_FAILSAFE_ENTRY
      |=> bus1_q[2] == $past(bus1_q[2]))
      else $error("selective wake changed by hardware");
   a_sleep_can_wake: assert property (I_SLEEP_ENTRY && !I_SOFT_RESET && !I_FAILSAFE_ENTRY
      && bus1_q[1:0] == 2'b11 && !I_SYSTEM_ERROR_FLAG |=> bus1_q[1:0] == 2'b01)
      else $error("normal CAN not made wake capable on sleep");
   a_stop_keep_rx: assert property (I_STOP_ENTRY && !wr_ok && !I_SOFT_RESET
      && !I_FAILSAFE_ENTRY && !I_SLEEP_ENTRY |=> $stable(bus1_q))
      else $error("stop entry changed bus modes");
   a_fs_values: assert property (I_FAILSAFE_ENTRY && !I_SOFT_RESET
      |=> bus1_q[4:0] == 5'h09 && bus2_q == 8'h01 && (wk2_q & 8'h5f) == 8'h07)
      else $error("fail-safe wake values not loaded");
   a_peak_stop_lock: assert property (stop_mode && !I_SOFT_RESET && !I_FAILSAFE_ENTRY
      |=> $stable(bus2_q[5]))
      else $error("peak threshold changed in stop");
   a_reserved_zero: assert property ((wd_q[3] | hw_q[2] | (bus2_q & 8'hdc) != 8'h00
      | (wk2_q & 8'h58) != 8'h00) == 1'b0)
      else $error("reserved bit set");
   a_int_source: assert property (I_STATUS_EVT && wk2_q[7] || I_WAKE_EVT |=> O_INT)
      else $error("interrupt missed");
   a_write_at_frame: assert property (!wr_ok && !I_SOFT_RESET && !I_FAILSAFE_ENTRY
      && !I_SLEEP_ENTRY |=> $stable(bus1_q))
      else $error("bus register changed outside a frame end");
   c_bus1_write: cover property (wr_ok && wr_addr == `WBMC_ADDR_BUS1);
   c_wd_bad_par: cover property (wr_ok && wr_addr == `WBMC_ADDR_WD && wd_par_bad);
   c_sleep_entry: cover property (I_SLEEP_ENTRY && bus1_q[1:0] == 2'b11);
   c_failsafe: cover property (I_FAILSAFE_ENTRY);
endmodule : wbmc_regs
`default_nettype wire
